// *** hw/cfg_hdr_pkg.sv ***
// constants for the rom, capability pointer and interrupt select configuration registers
package cfg_hdr_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses in configuration space)
	// ----------------------------------------------------------------
	localparam logic [7:0] BOOT_ROM_BASE_ENABLE_OFS = 8'h30;
	localparam logic [7:0] CAPABILITY_LIST_POINTER_OFS = 8'h34;
	localparam logic [7:0] INTERRUPT_AND_LATENCY_SELECT_OFS = 8'h3C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ROM_BASE_LSB = 16;
	localparam int ROM_BASE_W = 16;
	localparam int ROM_DECODE_ENABLE_BIT = 0;
	localparam int MAX_LATENCY_LSB = 24;
	localparam int MIN_GRANT_LSB = 16;
	localparam int INTERRUPT_PIN_LSB = 8;
	localparam int INTERRUPT_LINE_LSB = 0;

	// ----------------------------------------------------------------
	// reset and fixed values
	// ----------------------------------------------------------------
	localparam logic [31:0] BOOT_ROM_RESET = 32'h0000_0000;
	localparam logic [31:0] CAPABILITY_LIST_POINTER_RESET = 32'h0000_0040;
	localparam logic [31:0] INTERRUPT_SELECT_RESET = 32'h340B_0100;
	localparam logic [7:0] CAPABILITY_LIST_OFFSET = 8'h40;
	localparam logic [7:0] MAX_LATENCY_RESET = 8'h34;
	localparam logic [7:0] MIN_GRANT_RESET = 8'h0B;
	localparam logic [7:0] INTERRUPT_PIN_VALUE = 8'h01;
	localparam logic [7:0] INTERRUPT_LINE_RESET = 8'h00;

endpackage : cfg_hdr_pkg

// *** hw/byte_field_reg.sv ***
// one byte of storage with byte-enabled write and an extra load port
`timescale 1ns/1ps
module byte_field_reg
	import cfg_hdr_pkg::*;
#(
	parameter logic [7:0] RESET_VAL = 8'h00
)(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic soft_reset_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic load_i,
	input wire logic [7:0] load_data_i,
	output logic [7:0] q_o
);
	logic [7:0] field_q;
	logic [7:0] field_d;

	// the loader has priority over a host write landing in the same cycle
	assign field_d = load_i ? load_data_i : (wr_i ? wdata_i : field_q);

	// soft reset freezes the field here, blocking writes and loads; only hard reset reloads
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			field_q <= RESET_VAL;
		else if (ce_i && !soft_reset_i)
			field_q <= field_d;
	end

	assign q_o = field_q;
endmodule : byte_field_reg

// *** hw/rom_base_reg.sv ***
// boot rom base address and decode enable storage
`timescale 1ns/1ps
module rom_base_reg
	import cfg_hdr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic [3:0] be_i,
	input wire logic [31:0] wdata_i,
	output logic [15:0] rom_base_o,
	output logic rom_en_o
);
	logic [15:0] base_q;
	logic [15:0] base_d;
	logic en_q;
	logic en_d;

	// byte lanes 2 and 3 carry the base; lane 0 carries the enable
	assign base_d[7:0] = (wr_i && be_i[2]) ? wdata_i[23:16] : base_q[7:0];
	assign base_d[15:8] = (wr_i && be_i[3]) ? wdata_i[31:24] : base_q[15:8];
	assign en_d = (wr_i && be_i[0]) ? wdata_i[ROM_DECODE_ENABLE_BIT] : en_q;

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			base_q <= BOOT_ROM_RESET[31:16];
			en_q <= BOOT_ROM_RESET[0];
		end
		else if (ce_i)
		begin
			base_q <= base_d;
			en_q <= en_d;
		end
	end

	assign rom_base_o = base_q;
	assign rom_en_o = en_q;
endmodule : rom_base_reg

// *** hw/pci_cfg_rom_cap_int_regs.sv ***
// configuration registers for boot rom, capability pointer and interrupt select
//
// How it works
// R1: host writes rom base in bits 31-16; it sets boot rom decode address.
// R2: rom size bits 15-11 and unused bits 10-1 always read zero.
// R3: rom enable set selects boot rom decode and blocks operational targets.
// R4: capability pointer is read-only, low byte 40h, upper bits zero.
// R5: maximum latency top byte initialises to 52 decimal.
// R6: minimum grant bits 23-16 initialise to 11 decimal.
// R7: both latency and grant fields may be reloaded from eeprom.
// R8: interrupt pin field is read-only, always one.
// R9: interrupt line low byte is read-write storage for host.
// R10: hard reset loads 340b0100h into interrupt select; soft reset keeps it.
// R11: hard reset clears boot rom register; soft reset keeps it.
// R12: hard reset loads 00000040h into capability pointer; soft reset keeps it.
// R13: writes to read-only and unused bits are ignored.
`timescale 1ns/1ps
module pci_cfg_rom_cap_int_regs
	import cfg_hdr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic soft_reset_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic ee_load_i,
	input wire logic [7:0] ee_max_latency_i,
	input wire logic [7:0] ee_min_grant_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_hit_o,
	output logic [15:0] rom_base_field_o,
	output logic rom_decode_enable_o,
	output logic operational_decode_enable_o,
	output logic [7:0] max_latency_field_o,
	output logic [7:0] min_grant_field_o,
	output logic [7:0] interrupt_line_field_o
);
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic sel_rom;
	logic sel_cap;
	logic sel_int;
	logic wr_rom;
	logic wr_int;

	// soft reset gates writes too, so no stored field changes while it is held; read data and hit still update
	assign sel_rom = (cfg_addr_i == BOOT_ROM_BASE_ENABLE_OFS);
	assign sel_cap = (cfg_addr_i == CAPABILITY_LIST_POINTER_OFS);
	assign sel_int = (cfg_addr_i == INTERRUPT_AND_LATENCY_SELECT_OFS);
	assign wr_rom = cfg_wr_i && sel_rom && !soft_reset_i;
	assign wr_int = cfg_wr_i && sel_int && !soft_reset_i;

	// ----------------------------------------------------------------
	// boot rom register
	// ----------------------------------------------------------------
	logic [15:0] rom_base;
	logic rom_en;

	// only base and enable are stored; size and unused bits have no flops
	rom_base_reg u_rom
	(
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i), // R11
		.ce_i(ce_i),
		.wr_i(wr_rom), // R1 R13
		.be_i(cfg_be_i),
		.wdata_i(cfg_wdata_i),
		.rom_base_o(rom_base),
		.rom_en_o(rom_en)
	);

	// ----------------------------------------------------------------
	// interrupt select register
	// ----------------------------------------------------------------
	logic [7:0] max_lat;
	logic [7:0] min_gnt;
	logic [7:0] int_line;

	// latency and grant: reset defaults, host byte writes and eeprom loads
	byte_field_reg #(.RESET_VAL(MAX_LATENCY_RESET)) u_max_lat // R5 R10
	(
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.soft_reset_i(soft_reset_i),
		.wr_i(wr_int && cfg_be_i[3]),
		.wdata_i(cfg_wdata_i[31:24]),
		.load_i(ee_load_i), // R7
		.load_data_i(ee_max_latency_i),
		.q_o(max_lat)
	);

	byte_field_reg #(.RESET_VAL(MIN_GRANT_RESET)) u_min_gnt // R6 R10
	(
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.soft_reset_i(soft_reset_i),
		.wr_i(wr_int && cfg_be_i[2]),
		.wdata_i(cfg_wdata_i[23:16]),
		.load_i(ee_load_i), // R7
		.load_data_i(ee_min_grant_i),
		.q_o(min_gnt)
	);

	// interrupt line: host storage only, no eeprom path
	byte_field_reg #(.RESET_VAL(INTERRUPT_LINE_RESET)) u_int_line
	(
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.soft_reset_i(soft_reset_i),
		.wr_i(wr_int && cfg_be_i[0]), // R9
		.wdata_i(cfg_wdata_i[7:0]),
		.load_i(1'b0),
		.load_data_i(8'h00),
		.q_o(int_line)
	);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [31:0] rom_word;
	logic [31:0] cap_word;
	logic [31:0] int_word;
	logic [31:0] rdata_d;

	// fixed fields are wired constants, so writes cannot reach them
	assign rom_word = {rom_base, 15'h0000, rom_en}; // R2 R13
	assign cap_word = {24'h000000, CAPABILITY_LIST_OFFSET}; // R4 R12
	assign int_word = {max_lat, min_gnt, INTERRUPT_PIN_VALUE, int_line}; // R8
	assign rdata_d = sel_rom ? rom_word :
		sel_cap ? cap_word :
		sel_int ? int_word : 32'h0000_0000;

	// read data and hit are registered, one cycle after the request
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			cfg_rdata_o <= 32'h0000_0000;
			cfg_hit_o <= 1'b0;
		end
		else if (ce_i)
		begin
			cfg_rdata_o <= cfg_rd_i ? rdata_d : 32'h0000_0000;
			cfg_hit_o <= (cfg_rd_i || cfg_wr_i) && (sel_rom || sel_cap || sel_int);
		end
	end

	// ----------------------------------------------------------------
	// output staging, straight from flops
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			rom_base_field_o <= BOOT_ROM_RESET[31:16];
			rom_decode_enable_o <= 1'b0;
			operational_decode_enable_o <= 1'b1;
			max_latency_field_o <= MAX_LATENCY_RESET;
			min_grant_field_o <= MIN_GRANT_RESET;
			interrupt_line_field_o <= INTERRUPT_LINE_RESET;
		end
		else if (ce_i)
		begin
			rom_base_field_o <= rom_base;
			rom_decode_enable_o <= rom_en; // R3
			operational_decode_enable_o <= !rom_en; // R3
			max_latency_field_o <= max_lat;
			min_grant_field_o <= min_gnt;
			interrupt_line_field_o <= int_line;
		end
	end
endmodule : pci_cfg_rom_cap_int_regs

// *** sim/cfg_regs_asserts.sv ***
// checker on the configuration register ports
`timescale 1ns/1ps
module cfg_regs_asserts (
	input logic mclk_i,
	input logic reset_n_i,
	input logic ce_i,
	input logic soft_reset_i,
	input logic cfg_wr_i,
	input logic cfg_rd_i,
	input logic [7:0] cfg_addr_i,
	input logic [3:0] cfg_be_i,
	input logic [31:0] cfg_wdata_i,
	input logic ee_load_i,
	input logic [7:0] ee_max_latency_i,
	input logic [31:0] cfg_rdata_o,
	input logic cfg_hit_o,
	input logic rom_decode_enable_o,
	input logic operational_decode_enable_o,
	input logic [7:0] max_latency_field_o,
	input logic [7:0] interrupt_line_field_o
);
	// ----
	// requests that take effect
	// ----
	wire logic rd = cfg_rd_i && ce_i;
	wire logic wr = cfg_wr_i && ce_i && !soft_reset_i && cfg_be_i[0];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	property p_cap; rd && cfg_addr_i == 8'h34 |=> cfg_rdata_o == 32'h0000_0040; endproperty
	a_cap: assert property (p_cap) else $error("cap pointer");
	property p_gap; rd && cfg_addr_i == 8'h30 |=> cfg_rdata_o[15:1] == 15'h0000; endproperty
	a_gap: assert property (p_gap) else $error("rom size bits");
	property p_pin; rd && cfg_addr_i == 8'h3C |=> cfg_rdata_o[15:8] == 8'h01; endproperty
	a_pin: assert property (p_pin) else $error("interrupt pin");
	property p_dec; operational_decode_enable_o != rom_decode_enable_o; endproperty
	a_dec: assert property (p_dec) else $error("decode select");
	// outputs trail the store by one staging edge, so look two edges on
	property p_rom; wr && cfg_addr_i == 8'h30 ##1 ce_i[*2]
		|-> rom_decode_enable_o == $past(cfg_wdata_i[0], 2); endproperty
	a_rom: assert property (p_rom) else $error("rom enable");
	property p_line; wr && cfg_addr_i == 8'h3C ##1 ce_i[*2]
		|-> interrupt_line_field_o == $past(cfg_wdata_i[7:0], 2); endproperty
	a_line: assert property (p_line) else $error("interrupt line");
	property p_ee; ee_load_i && ce_i && !soft_reset_i ##1 ce_i[*2]
		|-> max_latency_field_o == $past(ee_max_latency_i, 2); endproperty
	a_ee: assert property (p_ee) else $error("eeprom latency");
	property p_rst; disable iff (1'b0) !reset_n_i ##1 !reset_n_i |-> !rom_decode_enable_o
		&& max_latency_field_o == 8'h34 && interrupt_line_field_o == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("hard reset");
	// any taken request to a mapped offset answers with a hit on the next edge
	property p_hit; (cfg_rd_i || cfg_wr_i) && ce_i && (cfg_addr_i == 8'h30
		|| cfg_addr_i == 8'h34 || cfg_addr_i == 8'h3C) |=> cfg_hit_o; endproperty
	a_hit: assert property (p_hit) else $error("mapped hit");
	property p_miss; rd && cfg_addr_i == 8'h38 |=> cfg_rdata_o == 32'h0000_0000
		&& !cfg_hit_o; endproperty
	a_miss: assert property (p_miss) else $error("unmapped read");
	// a low enable must hold read data, hit, rom decode enable, max latency and interrupt line outputs
	property p_frz; !ce_i |=> $stable(cfg_rdata_o) && $stable(cfg_hit_o)
		&& $stable(rom_decode_enable_o) && $stable(max_latency_field_o)
		&& $stable(interrupt_line_field_o); endproperty
	a_frz: assert property (p_frz) else $error("clock enable freeze");
endmodule : cfg_regs_asserts
bind pci_cfg_rom_cap_int_regs cfg_regs_asserts cfg_regs_asserts_inst (.*);

// *** sim/cfg_host_model.sv ***
// host bridge model issuing configuration cycles
`timescale 1ns/1ps
module cfg_host_model (
	input logic mclk_i,
	input logic [31:0] cfg_rdata_i,
	output logic cfg_wr_o,
	output logic cfg_rd_o,
	output logic [7:0] cfg_addr_o,
	output logic [3:0] cfg_be_o,
	output logic [31:0] cfg_wdata_o
);
	// idle bus from time zero
	initial
	begin
		{cfg_wr_o, cfg_rd_o} = 2'b00;
		{cfg_addr_o, cfg_be_o, cfg_wdata_o} = 44'h0;
	end
	// one strobe cycle; answer taken at the next falling edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] q);
		@(negedge mclk_i);
		{cfg_wr_o, cfg_rd_o} = {w, !w};
		{cfg_addr_o, cfg_be_o, cfg_wdata_o} = {a, b, d};
		@(negedge mclk_i);
		q = cfg_rdata_i;
		{cfg_wr_o, cfg_rd_o} = 2'b00;
		// released address and data lines show the inverse; byte enables keep the stale value
		{cfg_addr_o, cfg_wdata_o} = {~a, ~d};
	endtask : xfer
endmodule : cfg_host_model

// *** sim/testbench.sv ***
// self-checking bench for the configuration register block
`timescale 1ns/1ps
module testbench
	import cfg_hdr_pkg::*;
;
	logic mclk_i = 1'b0, reset_n_i = 1'b0, soft_reset_i = 1'b0, ee_load_i = 1'b0;
	logic ce_i = 1'b1;
	logic [7:0] ee_max_latency_i = 8'h00, ee_min_grant_i = 8'h00;
	logic cfg_wr_i, cfg_rd_i, cfg_hit_o, rom_decode_enable_o, operational_decode_enable_o;
	logic [7:0] cfg_addr_i, max_latency_field_o, min_grant_field_o, interrupt_line_field_o;
	logic [3:0] cfg_be_i;
	logic [15:0] rom_base_field_o;
	logic [31:0] cfg_wdata_i, cfg_rdata_o, q, e_rom, e_int;
	int n_fail = 0, tests_run = 0, cyc = 0;
	cfg_host_model host_inst (.mclk_i, .cfg_rdata_i(cfg_rdata_o), .cfg_wr_o(cfg_wr_i),
		.cfg_rd_o(cfg_rd_i), .cfg_addr_o(cfg_addr_i), .cfg_be_o(cfg_be_i),
		.cfg_wdata_o(cfg_wdata_i));
	// clock enable is driven by the bench so that freezing is exercised
	pci_cfg_rom_cap_int_regs pci_cfg_rom_cap_int_regs_inst (.*);
	initial
	begin
		forever #2 mclk_i = ~mclk_i;
	end
	// cycle ceiling well above the few hundred the run needs
	always @(posedge mclk_i)
	begin
		cyc = cyc + 1;
		if (cyc == 3000)
		begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// byte-enabled merge limited to the writable bits
	function automatic logic [31:0] mrg(input logic [31:0] o, d, input logic [3:0] b,
		input logic [31:0] m);
		logic [31:0] w;
		w = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & m;
		return (o & ~w) | (d & w);
	endfunction : mrg
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		host_inst.xfer(1'b1, a, b, d, q);
		if (ce_i)
			chk("write hit", {31'h0, cfg_hit_o}, {31'h0, a != 8'h38});
		if (ce_i && !soft_reset_i && a == 8'h30)
			e_rom = mrg(e_rom, d, b, 32'hFFFF_0001);
		if (ce_i && !soft_reset_i && a == 8'h3C)
			e_int = mrg(e_int, d, b, 32'hFFFF_00FF);
	endtask : wr
	task automatic ee();
		@(negedge mclk_i);
		ee_max_latency_i = 8'($urandom);
		ee_min_grant_i = 8'($urandom);
		ee_load_i = 1'b1;
		@(negedge mclk_i);
		ee_load_i = 1'b0;
		if (ce_i && !soft_reset_i)
			e_int[31:16] = {ee_max_latency_i, ee_min_grant_i};
	endtask : ee
	task automatic chkall(input string nm);
		host_inst.xfer(1'b0, 8'h30, 4'hF, 32'h0, q);
		chk("rom reg", q, e_rom);
		chk("read hit", {31'h0, cfg_hit_o}, 32'h0000_0001);
		host_inst.xfer(1'b0, 8'h38, 4'hF, 32'h0, q);
		chk("unmapped", {q[30:0], cfg_hit_o}, 32'h0000_0000);
		host_inst.xfer(1'b0, 8'h34, 4'hF, 32'h0, q);
		chk("cap reg", q, CAPABILITY_LIST_POINTER_RESET);
		host_inst.xfer(1'b0, 8'h3C, 4'hF, 32'h0, q);
		chk("int reg", q, e_int);
		chk("decode", {rom_base_field_o, 14'h0, operational_decode_enable_o,
			rom_decode_enable_o}, {e_rom[31:16], 14'h0, !e_rom[0], e_rom[0]});
		chk("fields", {max_latency_field_o, min_grant_field_o, 8'h01,
			interrupt_line_field_o}, e_int);
		$display("test %s done", nm);
	endtask : chkall
	initial
	begin
		void'($urandom(92732));
		repeat (8) @(negedge mclk_i);
		reset_n_i = 1'b1;
		e_rom = BOOT_ROM_RESET;
		e_int = INTERRUPT_SELECT_RESET;
		chkall("reset");
		wr(8'h34, 4'hF, 32'hFFFF_FFFF);
		wr(8'h30, 4'hF, 32'hFFFF_FFFF);
		wr(8'h3C, 4'hF, 32'hFFFF_FFFF);
		chkall("ones");
		repeat (24)
		begin
			wr(8'h30 + 8'(4 * ($urandom % 4)), 4'($urandom), $urandom);
			chkall("random");
		end
		ee();
		chkall("eeprom");
		// with the enable low nothing may move, not even the read data
		ce_i = 1'b0;
		wr(8'h3C, 4'hF, $urandom);
		chk("frozen rdata", q, e_int);
		ee();
		ce_i = 1'b1;
		chkall("freeze");
		soft_reset_i = 1'b1;
		wr(8'h3C, 4'hF, 32'h0);
		wr(8'h30, 4'hF, 32'h0);
		ee();
		chkall("soft");
		soft_reset_i = 1'b0;
		reset_n_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		reset_n_i = 1'b1;
		e_rom = BOOT_ROM_RESET;
		e_int = INTERRUPT_SELECT_RESET;
		chkall("hard");
		give_verdict();
	end
endmodule : testbench
